// File: flash_ctrl_pkg.sv
// Purpose: Shared constants for the flash program/erase sequencer
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes:   Operation timing is counted in system clock cycles
package flash_ctrl_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_CONTROL    = 12'h000;
    localparam logic [11:0] OFS_KEY        = 12'h004;
    localparam logic [11:0] OFS_PAGE_ADDR  = 12'h008;
    localparam logic [11:0] OFS_TABLE_LOW  = 12'h00c;
    localparam logic [11:0] OFS_TABLE_HIGH = 12'h010;

    // Control register fields
    localparam int BIT_START  = 15;
    localparam int BIT_ENABLE = 14;
    localparam int BIT_ERROR  = 13;
    localparam int BIT_ERASE  = 6;
    localparam int OP_MSB     = 3;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // Unlock key values
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // Operation codes
    localparam logic [3:0] OP_CONFIG_BYTE = 4'h0;
    localparam logic [3:0] OP_ROW         = 4'h1;
    localparam logic [3:0] OP_PAGE        = 4'h2;
    localparam logic [3:0] OP_WORD        = 4'h3;
    localparam logic [3:0] OP_SECURE_SEG  = 4'hc;
    localparam logic [3:0] OP_GENERAL_SEG = 4'hd;
    localparam logic [3:0] OP_BULK        = 4'hf;

    // Array geometry in instruction words
    localparam int ROW_WORDS  = 64;
    localparam int PAGE_WORDS = 512;

    // Row write: 11064 cycles of the 7.37 MHz internal RC oscillator
    localparam int    ROW_RC_CYCLES = 11064;
    localparam real   RC_FREQ_MHZ   = 7.37;
    localparam real   SYS_FREQ_MHZ  = 100.0;
    localparam int    ROW_SYS_CYCLES = int'($ceil(ROW_RC_CYCLES * SYS_FREQ_MHZ / RC_FREQ_MHZ));

    // Array operation kinds
    typedef enum logic [3:0] {
        KIND_NONE    = 4'h0,
        KIND_ROW     = 4'h1,
        KIND_WORD    = 4'h2,
        KIND_PAGE    = 4'h3,
        KIND_SEGMENT = 4'h4,
        KIND_BULK    = 4'h5,
        KIND_CONFIG  = 4'h6
    } op_kind_t;

endpackage : flash_ctrl_pkg

// File: op_timer.sv
`timescale 1ns/1ps
// Purpose: Self-timed operation counter
// Assumes: start is a one-cycle pulse while idle
// Notes:   done pulses one cycle after the count runs out
module op_timer #(
    parameter int CYCLES = 1000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    // Parameter limit
    if (CYCLES < 2) begin : g_bad_cycles
        $error("op_timer: CYCLES must be at least 2");
    end

    logic [$clog2(CYCLES+1)-1:0] count_reg, count_next;
    logic                        busy_reg, busy_next;
    logic                        done_reg, done_next;

    // Next count
    always_comb begin
        count_next = count_reg;
        busy_next  = busy_reg;
        done_next  = 1'b0;
        if (start && !busy_reg) begin
            count_next = ($clog2(CYCLES+1))'(CYCLES - 1);
            busy_next  = 1'b1;
        end else if (busy_reg) begin
            if (count_reg == '0) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                count_next = count_reg - 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
endmodule : op_timer

// File: flash_program_erase_control.sv
`timescale 1ns/1ps
// Purpose: APB-controlled sequencer for self-timed flash program and erase
// Assumes: arst_n is the power-on reset; other resets never reach this block
// Notes:   Array times are parameters so simulation can shorten them
module flash_program_erase_control #(
    parameter int ADDR_W        = 24,
    parameter int ROW_CYCLES    = flash_ctrl_pkg::ROW_SYS_CYCLES,
    parameter int ERASE_CYCLES  = flash_ctrl_pkg::ROW_SYS_CYCLES
) (
    // Clock and power-on reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // CPU stall
    output logic                   cpu_stall,
    // Flash array command
    output logic                   array_go,
    output flash_ctrl_pkg::op_kind_t array_kind,
    output logic [ADDR_W-1:0]      array_addr,
    output logic                   array_busy
);
    // Parameter limits that the logic can serve
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end
    if (ROW_CYCLES < 2 || ERASE_CYCLES < 2) begin : g_bad_cycles
        $error("operation times must be at least two cycles");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic flash_ctrl_pkg::op_kind_t decode_op(input logic erase, input logic [3:0] op);
        decode_op = flash_ctrl_pkg::KIND_NONE;
        unique case (op)
            flash_ctrl_pkg::OP_BULK:        if (erase) decode_op = flash_ctrl_pkg::KIND_BULK;
            flash_ctrl_pkg::OP_GENERAL_SEG,
            flash_ctrl_pkg::OP_SECURE_SEG:  if (erase) decode_op = flash_ctrl_pkg::KIND_SEGMENT;
            flash_ctrl_pkg::OP_WORD:        if (!erase) decode_op = flash_ctrl_pkg::KIND_WORD;
            flash_ctrl_pkg::OP_PAGE:        if (erase) decode_op = flash_ctrl_pkg::KIND_PAGE;
            flash_ctrl_pkg::OP_ROW:         if (!erase) decode_op = flash_ctrl_pkg::KIND_ROW;
            flash_ctrl_pkg::OP_CONFIG_BYTE: decode_op = flash_ctrl_pkg::KIND_CONFIG;
            default:                        decode_op = flash_ctrl_pkg::KIND_NONE;
        endcase
    endfunction : decode_op

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Base of the aligned block of the given number of instruction words
    function automatic logic [ADDR_W-1:0] block_base(input logic [ADDR_W-1:0] a, input int words);
        block_base = a & ~ADDR_W'(2 * words - 1);
    endfunction : block_base

    // Address handed to the array: page base, row base or the plain pointer
    function automatic logic [ADDR_W-1:0] launch_addr(input flash_ctrl_pkg::op_kind_t k,
                                                      input logic [ADDR_W-1:0]        page,
                                                      input logic [ADDR_W-1:0]        ptr);
        unique case (k)
            flash_ctrl_pkg::KIND_PAGE: launch_addr = page;
            flash_ctrl_pkg::KIND_ROW:  launch_addr = block_base(ptr, flash_ctrl_pkg::ROW_WORDS);
            default:                   launch_addr = ptr;
        endcase
    endfunction : launch_addr

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_DONE  = 3'b100
    } seq_state_t;

    seq_state_t               state_reg, state_next;
    logic                     start_reg, start_next;
    logic                     enable_reg, enable_next;
    logic                     error_reg, error_next;
    logic                     erase_reg, erase_next;
    logic [3:0]               op_reg, op_next;
    logic [1:0]               key_reg, key_next;     // 0 none, 1 first seen, 2 unlocked
    logic [ADDR_W-1:0]        page_reg, page_next;
    logic [ADDR_W-1:0]        ptr_reg, ptr_next;
    logic [ADDR_W-1:0]        addr_reg, addr_next;   // Target latched at launch
    flash_ctrl_pkg::op_kind_t kind_reg, kind_next;
    logic                     go_next;
    logic                     go_reg;

    logic        wr_access;
    logic        rd_setup;
    logic        row_busy, row_done, erase_busy, erase_done;
    logic        long_kind;
    logic [31:0] rdata_next;

    assign wr_access = psel && penable && pwrite;
    assign rd_setup  = psel && !penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Timers for row program and erase; word and config use the row timer

    assign long_kind = (kind_reg == flash_ctrl_pkg::KIND_PAGE) ||
                       (kind_reg == flash_ctrl_pkg::KIND_SEGMENT) ||
                       (kind_reg == flash_ctrl_pkg::KIND_BULK);

    op_timer #(.CYCLES(ROW_CYCLES)) u_row_timer (
        .clk    (clk),
        .arst_n (arst_n),
        .start  (go_reg && !long_kind),
        .busy   (row_busy),
        .done   (row_done)
    );

    op_timer #(.CYCLES(ERASE_CYCLES)) u_erase_timer (
        .clk    (clk),
        .arst_n (arst_n),
        .start  (go_reg && long_kind),
        .busy   (erase_busy),
        .done   (erase_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register and sequence next state

    always_comb begin
        state_next  = state_reg;
        start_next  = start_reg;
        enable_next = enable_reg;
        error_next  = error_reg;
        erase_next  = erase_reg;
        op_next     = op_reg;
        key_next    = key_reg;
        page_next   = page_reg;
        ptr_next    = ptr_reg;
        addr_next   = addr_reg;
        kind_next   = kind_reg;
        go_next     = 1'b0;

        // Any write other than to the key or control register breaks the key sequence
        if (wr_access && !hit(paddr, flash_ctrl_pkg::OFS_KEY) && !hit(paddr, flash_ctrl_pkg::OFS_CONTROL)) begin
            key_next = 2'd0;
        end

        if (wr_access && hit(paddr, flash_ctrl_pkg::OFS_KEY) && pstrb[0]) begin
            if (pwdata[7:0] == flash_ctrl_pkg::KEY_FIRST) begin
                key_next = 2'd1;
            end else if (pwdata[7:0] == flash_ctrl_pkg::KEY_SECOND && key_reg == 2'd1) begin
                key_next = 2'd2;
            end else begin
                key_next = 2'd0;
            end
        end

        if (wr_access && hit(paddr, flash_ctrl_pkg::OFS_PAGE_ADDR)) begin
            ptr_next = pwdata[ADDR_W-1:0];
        end

        // Dummy low-word table write latches the page base
        if (wr_access && hit(paddr, flash_ctrl_pkg::OFS_TABLE_LOW)) begin
            page_next = block_base(ptr_reg, flash_ctrl_pkg::PAGE_WORDS);
        end

        if (wr_access && hit(paddr, flash_ctrl_pkg::OFS_CONTROL) && state_reg == ST_IDLE) begin
            if (pstrb[0]) begin
                erase_next = pwdata[flash_ctrl_pkg::BIT_ERASE];
                op_next    = pwdata[flash_ctrl_pkg::OP_MSB:0];
            end
            if (pstrb[1]) begin
                enable_next = pwdata[flash_ctrl_pkg::BIT_ENABLE];
                error_next  = pwdata[flash_ctrl_pkg::BIT_ERROR];
                if (pwdata[flash_ctrl_pkg::BIT_START]) begin
                    key_next = 2'd0;
                    if (key_reg == 2'd2 && pwdata[flash_ctrl_pkg::BIT_ENABLE]) begin
                        start_next = 1'b1;
                        error_next = 1'b0;
                        kind_next  = decode_op(pstrb[0] ? pwdata[flash_ctrl_pkg::BIT_ERASE] : erase_reg,
                                               pstrb[0] ? pwdata[flash_ctrl_pkg::OP_MSB:0] : op_reg);
                        addr_next  = launch_addr(kind_next, page_reg, ptr_reg);
                        go_next    = 1'b1;
                        state_next = ST_RUN;
                    end else begin
                        error_next = 1'b1;
                    end
                end
            end
        end else if (wr_access && hit(paddr, flash_ctrl_pkg::OFS_CONTROL) && pwdata[flash_ctrl_pkg::BIT_START]) begin
            // Start attempt while running is an improper sequence
            error_next = 1'b1;
        end

        unique case (state_reg)
            ST_IDLE: ;
            ST_RUN: begin
                if (row_done || erase_done) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                start_next = 1'b0;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit(paddr, flash_ctrl_pkg::OFS_CONTROL)) begin
            rdata_next[flash_ctrl_pkg::BIT_START]  = start_reg;
            rdata_next[flash_ctrl_pkg::BIT_ENABLE] = enable_reg;
            rdata_next[flash_ctrl_pkg::BIT_ERROR]  = error_reg;
            rdata_next[flash_ctrl_pkg::BIT_ERASE]  = erase_reg;
            rdata_next[flash_ctrl_pkg::OP_MSB:0]   = op_reg;
        end else if (hit(paddr, flash_ctrl_pkg::OFS_PAGE_ADDR)) begin
            rdata_next[ADDR_W-1:0] = ptr_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers; arst_n is power-on reset only

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg  <= ST_IDLE;
            start_reg  <= flash_ctrl_pkg::CONTROL_RESET[flash_ctrl_pkg::BIT_START];
            enable_reg <= flash_ctrl_pkg::CONTROL_RESET[flash_ctrl_pkg::BIT_ENABLE];
            error_reg  <= flash_ctrl_pkg::CONTROL_RESET[flash_ctrl_pkg::BIT_ERROR];
            erase_reg  <= flash_ctrl_pkg::CONTROL_RESET[flash_ctrl_pkg::BIT_ERASE];
            op_reg     <= flash_ctrl_pkg::CONTROL_RESET[flash_ctrl_pkg::OP_MSB:0];
            key_reg    <= 2'd0;
            page_reg   <= '0;
            ptr_reg    <= '0;
            addr_reg   <= '0;
            kind_reg   <= flash_ctrl_pkg::KIND_NONE;
            go_reg     <= 1'b0;
            prdata     <= 32'h0000_0000;
        end else begin
            state_reg  <= state_next;
            start_reg  <= start_next;
            enable_reg <= enable_next;
            error_reg  <= error_next;
            erase_reg  <= erase_next;
            op_reg     <= op_next;
            key_reg    <= key_next;
            page_reg   <= page_next;
            ptr_reg    <= ptr_next;
            addr_reg   <= addr_next;
            kind_reg   <= kind_next;
            go_reg     <= go_next;
            if (rd_setup) begin
                prdata <= rdata_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign pready     = 1'b1;
    assign pslverr    = 1'b0;
    assign cpu_stall  = start_reg;
    assign array_go   = go_reg;
    assign array_kind = kind_reg;
    assign array_addr = addr_reg;
    assign array_busy = row_busy || erase_busy;
endmodule : flash_program_erase_control

// File: flash_ctrl_chk.sv
`timescale 1ns/1ps
// Purpose: Port-level checks of the flash program/erase sequencer
// Assumes: One clock domain, arst_n asynchronous active low
// Notes:   Attached to the design by the bind at the foot
module flash_ctrl_chk #(
    parameter int ADDR_W       = 24,
    parameter int ROW_CYCLES   = 20,
    parameter int ERASE_CYCLES = 20
) (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     arst_n,
    // APB
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [3:0]               pstrb,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    // Stall and array command
    input wire logic                     cpu_stall,
    input wire logic                     array_go,
    input wire flash_ctrl_pkg::op_kind_t array_kind,
    input wire logic [ADDR_W-1:0]        array_addr,
    input wire logic                     array_busy
);
    localparam int HI = ((ERASE_CYCLES > ROW_CYCLES) ? ERASE_CYCLES : ROW_CYCLES) + 8;
    logic [15:0] stall_cnt_reg;
    logic [15:0] stall_cnt_next;
    ////////////////////////////////////////////////////////////////////////////
    // Length of the current stall
    always_comb stall_cnt_next = cpu_stall ? stall_cnt_reg + 16'h0001 : 16'h0000;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) stall_cnt_reg <= 16'h0000;
        else stall_cnt_reg <= stall_cnt_next;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence launch_seq;
        array_go ##1 (array_busy && !array_go);
    endsequence
    a_stall_then_launch: assert property ($rose(cpu_stall) |-> launch_seq)
        else $error("no launch after start");
    a_stall_has_cause: assert property ($rose(cpu_stall) |-> $past(psel && penable && pwrite &&
        paddr == 12'h000 && pwdata[15] && pwdata[14] && pstrb[1])) else $error("start without write");
    a_busy_stalls: assert property (array_busy |-> cpu_stall) else $error("busy without stall");
    a_go_when_idle: assert property (array_go |-> cpu_stall && !array_busy) else $error("bad launch");
    a_stall_length: assert property ($fell(cpu_stall) |-> stall_cnt_reg >= ROW_CYCLES &&
        stall_cnt_reg <= HI) else $error("stall length wrong");
    a_release_done: assert property ($fell(cpu_stall) |-> $past(!array_busy)) else $error("early release");
    a_unimpl_zero: assert property (psel && penable && !pwrite && paddr == 12'h000 |->
        prdata[31:16] == 16'h0000 && prdata[12:7] == 6'h00 && prdata[5:4] == 2'h0) else $error("unimpl bits");
    a_key_hidden: assert property (psel && penable && !pwrite && paddr == 12'h004 |->
        prdata == 32'h0) else $error("key readable");
    a_cmd_holds: assert property (array_busy |-> $stable(array_kind) && $stable(array_addr))
        else $error("command moved");
endmodule : flash_ctrl_chk

bind flash_program_erase_control flash_ctrl_chk #(.ADDR_W(ADDR_W), .ROW_CYCLES(ROW_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) flash_ctrl_chk_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall), .array_go(array_go),
    .array_kind(array_kind), .array_addr(array_addr), .array_busy(array_busy));

// File: flash_array_model.sv
`timescale 1ns/1ps
// Purpose: Behavioural flash array seen from the sequencer
// Assumes: One command per launch pulse
// Notes:   Records the last command and flags a launch into a busy array
module flash_array_model (
    // Clock
    input  wire logic                     clk,
    // Command from the sequencer
    input  wire logic                     array_go,
    input  wire flash_ctrl_pkg::op_kind_t array_kind,
    input  wire logic [23:0]              array_addr,
    input  wire logic                     array_busy,
    // Observed history
    output int                            op_count,
    output flash_ctrl_pkg::op_kind_t      last_kind,
    output logic [23:0]                   last_addr,
    output logic                          overlap
);
    // Empty history at start
    initial begin
        op_count = 0;
        overlap = 1'b0;
    end
    // Take one command per launch
    always @(posedge clk) begin
        if (array_go) begin
            op_count <= op_count + 1;
            last_kind <= array_kind;
            last_addr <= array_addr;
            if (array_busy) overlap <= 1'b1;
        end
    end
endmodule : flash_array_model

// File: flash_program_erase_control_tb_top.sv
`timescale 1ns/1ps
// Purpose: Self-checking bench of the flash sequencer
// Assumes: Zero-wait APB slave, array times shortened to 20 cycles
// Notes:   Each scenario is one task
module flash_program_erase_control_tb_top;
    localparam logic [11:0] CTL = flash_ctrl_pkg::OFS_CONTROL;
    localparam logic [11:0] KEY = flash_ctrl_pkg::OFS_KEY;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, cpu_stall, array_go, array_busy, overlap;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [23:0] array_addr, last_addr;
    flash_ctrl_pkg::op_kind_t array_kind, last_kind;
    int op_count;
    int bad_count = 0;
    int check_count = 0;
    ////////////////////////////////////////////////////////////////////////////
    // Design and array model
    flash_program_erase_control #(.ROW_CYCLES(20), .ERASE_CYCLES(20)) flash_program_erase_control_inst (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_stall(cpu_stall), .array_go(array_go), .array_kind(array_kind), .array_addr(array_addr),
        .array_busy(array_busy));
    flash_array_model flash_array_model_inst (.clk(clk), .array_go(array_go), .array_kind(array_kind),
        .array_addr(array_addr), .array_busy(array_busy), .op_count(op_count), .last_kind(last_kind),
        .last_addr(last_addr), .overlap(overlap));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #400000;
        bad_count++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask : rd_chk
    task automatic unlock();
        wr(KEY, 32'h55);
        wr(KEY, 32'haa);
    endtask : unlock
    task automatic wait_idle();
        int n;
        n = 0;
        while (cpu_stall !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) begin
            bad_count++;
            complete_run();
        end
    endtask : wait_idle
    function automatic flash_ctrl_pkg::op_kind_t exp_kind(input logic er, input logic [3:0] c);
        if (c == 4'h0) return flash_ctrl_pkg::KIND_CONFIG;
        if (er) begin
            if (c == 4'hf) return flash_ctrl_pkg::KIND_BULK;
            if (c == 4'hc || c == 4'hd) return flash_ctrl_pkg::KIND_SEGMENT;
            if (c == 4'h2) return flash_ctrl_pkg::KIND_PAGE;
        end else begin
            if (c == 4'h3) return flash_ctrl_pkg::KIND_WORD;
            if (c == 4'h1) return flash_ctrl_pkg::KIND_ROW;
        end
        return flash_ctrl_pkg::KIND_NONE;
    endfunction : exp_kind
    task automatic do_op(input logic er, input logic [3:0] c);
        int b;
        logic [31:0] ctl;
        flash_ctrl_pkg::op_kind_t k;
        b = op_count;
        ctl = 32'h4000 | {25'h0, er, 2'b00, c};
        k = exp_kind(er, c);
        wr(CTL, ctl);
        unlock();
        wr(CTL, ctl | 32'h8000);
        repeat (2) @(posedge clk);
        wait_idle();
        if (k != flash_ctrl_pkg::KIND_NONE || op_count != b) begin
            chk("op count", 32'(b + 1), 32'(op_count));
            chk("op kind", 32'(k), 32'(last_kind));
        end
        rd_chk("control after op", CTL, ctl);
    endtask : do_op
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_refused();
        rd_chk("control at reset", CTL, 32'h0);
        rd_chk("key read", KEY, 32'h0);
        rd_chk("unmapped read", 12'h01c, 32'h0);
        wr(CTL, 32'hc001);
        rd_chk("start without key", CTL, 32'h6001);
        unlock();
        wr(CTL, 32'h8001);
        rd_chk("start disabled", CTL, 32'h2001);
        wr(KEY, 32'haa);
        wr(KEY, 32'h55);
        wr(CTL, 32'hc001);
        rd_chk("keys reversed", CTL, 32'h6001);
        wr(KEY, 32'h55);
        wr(12'h008, 32'h0);
        wr(KEY, 32'haa);
        wr(CTL, 32'hc001);
        rd_chk("keys split", CTL, 32'h6001);
        chk("no op launched", 32'h0, 32'(op_count));
        $display("test refused done");
    endtask : t_refused
    task automatic t_ops();
        logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hc, 4'hd, 4'he, 4'hf};
        for (int er = 0; er < 2; er++) begin
            foreach (codes[i]) do_op(er[0], codes[i]);
        end
        $display("test codes done");
    endtask : t_ops
    task automatic t_page();
        wr(12'h008, 32'h00012345);
        wr(12'h00c, 32'h0000beef);
        do_op(1'b1, 4'h2);
        chk("page base", 32'h00012000, {8'h0, last_addr});
        chk("overlap", 32'h0, {31'h0, overlap});
        $display("test page done");
    endtask : t_page
    task automatic t_row();
        for (int i = 0; i < 4; i++) begin
            wr(12'h008, 32'h180 + 32'(2 * i));
            wr(12'h00c, 32'(i));
            wr(12'h010, 32'h0);
        end
        do_op(1'b0, 4'h1);
        chk("row base", 32'h00000180, {8'h0, last_addr});
        $display("test row done");
    endtask : t_row
    task automatic t_running();
        unlock();
        wr(CTL, 32'hc001);
        rd_chk("start running", CTL, 32'hc001);
        wr(CTL, 32'h4001);
        rd_chk("start kept", CTL, 32'hc001);
        chk("stall running", 32'h1, {31'h0, cpu_stall});
        wait_idle();
        rd_chk("start cleared", CTL, 32'h4001);
        $display("test running done");
    endtask : t_running
    task automatic t_reset_mid();
        unlock();
        wr(CTL, 32'hc001);
        repeat (5) @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("stall in reset", 32'h0, {31'h0, cpu_stall});
        arst_n <= 1'b1;
        rd_chk("control after reset", CTL, 32'h0);
        $display("test reset done");
    endtask : t_reset_mid
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        arst_n = 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_refused();
        t_ops();
        t_page();
        t_row();
        t_running();
        t_reset_mid();
        complete_run();
    end
endmodule : flash_program_erase_control_tb_top
